// File: bench/b4q_ctrl_model.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------
// controller model: link clock, commands, write beats, read capture
// ----------------------------------------------------------------
module b4q_ctrl_model #(
    parameter int DATA_W = 36,
    parameter int ADDR_W = 6
) (
    // link side drive
    output logic link_clk_out,
    output logic rd_sel_n_out,
    output logic wr_sel_n_out,
    output logic [ADDR_W-1:0] addr_out,
    output logic [DATA_W-1:0] data_out,
    output logic [DATA_W/9-1:0] bw_n_out,
    // read data back
    input wire logic [DATA_W-1:0] q_in,
    input wire logic q_oe_in
);
    localparam int LN = DATA_W / 9;

    // free running: the device syncs its reset with this clock
    initial begin
        link_clk_out = 1'b0;
        rd_sel_n_out = 1'b1;
        wr_sel_n_out = 1'b1;
        addr_out = '0;
        data_out = '0;
        bw_n_out = '1;
        #7;
        forever #16 link_clk_out = ~link_clk_out;
    end

    // write taken at edge t, read at t+1; dup repeats the write on purpose
    task automatic xfer(input logic do_wr, input logic do_rd, input logic dup,
                        input logic [ADDR_W-1:0] wa, input logic [ADDR_W-1:0] ra,
                        input logic [4*DATA_W-1:0] wd, input logic [4*LN-1:0] bw,
                        output logic [4*DATA_W-1:0] rd, output logic [4:0] oe);
        @(posedge link_clk_out);
        wr_sel_n_out <= ~do_wr;
        addr_out <= wa;
        @(posedge link_clk_out);
        wr_sel_n_out <= ~dup;
        rd_sel_n_out <= ~do_rd;
        addr_out <= dup ? ~wa : ra;
        data_out <= wd[0 +: DATA_W];
        bw_n_out <= bw[0 +: LN];
        @(posedge link_clk_out);
        wr_sel_n_out <= 1'b1;
        rd_sel_n_out <= 1'b1;
        addr_out <= ~addr_out;
        data_out <= wd[DATA_W +: DATA_W];
        bw_n_out <= bw[LN +: LN];
        @(negedge link_clk_out);
        data_out <= wd[2*DATA_W +: DATA_W];
        bw_n_out <= bw[2*LN +: LN];
        @(posedge link_clk_out);
        data_out <= wd[3*DATA_W +: DATA_W];
        bw_n_out <= bw[3*LN +: LN];
        @(negedge link_clk_out);
        // junk with every lane enabled, the device must drop it
        data_out <= ~data_out;
        bw_n_out <= '0;
        for (int k = 0; k < 5; k++) begin
            #8;
            if (k < 4) rd[k*DATA_W +: DATA_W] = q_in;
            oe[k] = q_oe_in;
            @(link_clk_out);
        end
    endtask : xfer
endmodule : b4q_ctrl_model

// File: bench/test_b4q_port.sv
`timescale 1ns/10ps

module test_b4q_port;
    localparam int DW = 36;
    localparam int AW = 6;
    localparam int LN = DW / 9;

    // ----------------------------------------------------------------
    // signals and state
    // ----------------------------------------------------------------
    logic clock_in, rst_in, link_clk, rd_sel_n, wr_sel_n, q_oe, deselected;
    logic echo, echo_n, imp_upd, imp_ready, single_mode;
    logic [AW-1:0] addr, wa, last_wa;
    logic [DW-1:0] data, q;
    logic [LN-1:0] bw_n;
    logic [4*LN-1:0] bw;
    logic [DW-1:0] ref_mem [0:63];
    logic [LN-1:0] lane_tab [0:4] = '{4'h0, 4'hE, 4'hD, 4'h3, 4'hF};
    int seed = 78205;
    int err_count = 0;
    int n_checks = 0;
    logic strap = 1'h1;
    logic seen_busy = 1'h0;

    b4q_port #(.DATA_W(DW), .ADDR_W(AW), .IMP_CYCLES(8)) u_b4q_port (
        .clock_in(clock_in), .rst_in(rst_in), .link_clk_in(link_clk),
        .rd_sel_n_in(rd_sel_n), .wr_sel_n_in(wr_sel_n), .shared_address_bus_in(addr),
        .data_in(data), .byte_write_n_in(bw_n), .out_clk_in(strap), .out_clk_n_in(strap),
        .q_out(q), .q_oe_out(q_oe), .echo_clock_out(echo), .echo_clock_n_out(echo_n),
        .impedance_update_out(imp_upd), .deselected_out(deselected),
        .impedance_ready_out(imp_ready), .single_clock_mode_out(single_mode));

    b4q_ctrl_model #(.DATA_W(DW), .ADDR_W(AW)) u_b4q_ctrl_model (
        .link_clk_out(link_clk), .rd_sel_n_out(rd_sel_n), .wr_sel_n_out(wr_sel_n),
        .addr_out(addr), .data_out(data), .bw_n_out(bw_n), .q_in(q), .q_oe_in(q_oe));

    // system clock, 50 ns
    initial clock_in = 1'b0;
    always #25 clock_in = ~clock_in;

    // deselected must drop at least once while bursts run
    always @(posedge clock_in) if (!deselected) seen_busy <= 1'h1;

    // ----------------------------------------------------------------
    // expectation helpers
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [DW-1:0] seen,
                         input logic [DW-1:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // only lanes whose enable is low take the new byte
    function automatic logic [DW-1:0] merge(input logic [DW-1:0] old,
                                            input logic [DW-1:0] nw, input logic [LN-1:0] b);
        logic [DW-1:0] r;
        r = old;
        for (int g = 0; g < LN; g++) if (!b[g]) r[g*9 +: 9] = nw[g*9 +: 9];
        return r;
    endfunction : merge

    // burst offsets wrap inside the group of four
    function automatic logic [AW-1:0] waddr(input logic [AW-1:0] a, input int k);
        return {a[AW-1:2], a[1:0] + 2'(k)};
    endfunction : waddr

    function automatic logic [4*DW-1:0] rnd_words();
        logic [159:0] t;
        t = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
        return t[4*DW-1:0];
    endfunction : rnd_words

    // one write and one read one edge later, then compare
    task automatic op(input logic do_wr, input logic do_rd, input logic dup,
                      input logic [AW-1:0] wa_i, input logic [AW-1:0] ra,
                      input logic [4*LN-1:0] bw_i);
        logic [4*DW-1:0] wd, rd;
        logic [4:0] oe;
        wd = rnd_words();
        u_b4q_ctrl_model.xfer(do_wr, do_rd, dup, wa_i, ra, wd, bw_i, rd, oe);
        if (do_wr) for (int k = 0; k < 4; k++)
            ref_mem[waddr(wa_i, k)] = merge(ref_mem[waddr(wa_i, k)], wd[k*DW +: DW],
                                            bw_i[k*LN +: LN]);
        for (int k = 0; k < 4; k++)
            if (do_rd) check("read word", rd[k*DW +: DW], ref_mem[waddr(ra, k)]);
        check("output enable", DW'(oe), do_rd ? DW'(5'h0F) : '0);
    endtask : op

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        rst_in = 1'b1;
        repeat (6) @(posedge clock_in);
        rst_in <= 1'b0;
        repeat (10) @(posedge link_clk);
        check("deselected after reset", DW'(deselected), DW'(1'b1));
        // fill every group, start offset random to exercise the wrap
        for (int g = 0; g < 16; g++) begin
            wa = {g[3:0], 2'($random(seed))};
            op(1'b1, 1'b0, 1'b0, wa, '0, '0);
        end
        last_wa = wa;
        // lane table first, then random enables per beat
        for (int i = 0; i < 40; i++) begin
            wa = AW'($random(seed));
            if (wa[AW-1:2] == last_wa[AW-1:2]) wa[2] = ~wa[2];
            bw = (i < 5) ? {4{lane_tab[i]}} : 16'($random(seed));
            op(1'b1, 1'b1, 1'b0, wa, last_wa, bw);
            last_wa = wa;
        end
        // second write on the next edge must be dropped
        op(1'b1, 1'b0, 1'b1, wa, '0, '0);
        op(1'b0, 1'b1, 1'b0, '0, ~wa, '0);
        op(1'b0, 1'b1, 1'b0, '0, wa, '0);
        repeat (20) @(posedge clock_in);
        check("deselected when idle", DW'(deselected), DW'(1'b1));
        check("impedance update idle", DW'(imp_upd), DW'(1'b1));
        check("impedance ready", DW'(imp_ready), DW'(1'b1));
        check("deselected during burst", DW'(seen_busy), DW'(1'h1));
        check("single clock mode", DW'(single_mode), DW'(1'b1));
        // low phase of the link clock: echo low, its complement high
        @(negedge link_clk);
        #1;
        check("echo pair", DW'({echo, echo_n}), DW'(2'h1));
        // strap dropped without reset: the latched mode must not follow it
        @(posedge clock_in);
        strap <= 1'h0;
        repeat (16) @(posedge link_clk);
        check("mode kept after strap change", DW'(single_mode), DW'(1'h1));
        // second reset with the strap low selects dual-clock timing
        @(posedge clock_in);
        rst_in <= 1'h1;
        repeat (6) @(posedge clock_in);
        check("impedance ready in reset", DW'(imp_ready), DW'(1'h0));
        rst_in <= 1'h0;
        repeat (16) @(posedge link_clk);
        check("dual clock mode", DW'(single_mode), DW'(1'h0));
        check("deselected after second reset", DW'(deselected), DW'(1'h1));
        tally_and_finish();
    end

    // cut a hang short
    initial begin
        #100000;
        err_count++;
        tally_and_finish();
    end

    task automatic tally_and_finish();
        if (err_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish
endmodule : test_b4q_port

// File: common/b4q_pkg.sv
// ----------------------------------------------------------------
// shared types
// ----------------------------------------------------------------
package b4q_pkg;

    // output timing mode, latched once after reset
    typedef enum logic {
        B4Q_DUAL_CLOCK,
        B4Q_SINGLE_CLOCK
    } b4q_mode_e;

endpackage : b4q_pkg

// File: common/b4q_regs.svh
`ifndef B4Q_REGS_SVH
`define B4Q_REGS_SVH

// ----------------------------------------------------------------
// data word and byte lane shape
// ----------------------------------------------------------------
`define B4Q_DATA_W_DEF 36
`define B4Q_ADDR_W_DEF 19
`define B4Q_LANE_W 9
`define B4Q_BURST_LEN 4

// ----------------------------------------------------------------
// burst word offsets from the captured start address
// ----------------------------------------------------------------
`define B4Q_OFF_0 2'h0
`define B4Q_OFF_1 2'h1
`define B4Q_OFF_2 2'h2
`define B4Q_OFF_3 2'h3

// ----------------------------------------------------------------
// timing counts and reset values
// ----------------------------------------------------------------
`define B4Q_IMP_CYCLES 1024
`define B4Q_FLAG_RST 1'h0

`endif

// File: core/b4q_port.sv
// How it works
// - write select low at rising edge captures address
// - each write stores exactly four words
// - write beats alternate rising, then falling edges
// - data outside an accepted burst is ignored
// - deselect only after the running burst ends
// - enables 0 and 1 gate the low lanes
// - enables 2 and 3 gate the high lanes
// - low enable stores its lane per beat
// - impedance update only while outputs are idle
// - clock mode latched once after reset
// - read and write ports are fully independent
// - pending bursts finish before reporting deselected
// - two burst machines, both on the rising edge
// - burst address is a 2-bit linear count
// - second request on the next edge is ignored
// - stopped clock holds all state
// - read data starts on the falling edge after next
// - read select low at rising edge captures address
// - echo clock pair runs free with the outputs
`timescale 1ns/10ps
`include "b4q_regs.svh"

module b4q_port #(
    parameter int DATA_W = `B4Q_DATA_W_DEF,
    parameter int ADDR_W = `B4Q_ADDR_W_DEF,
    parameter int IMP_CYCLES = `B4Q_IMP_CYCLES
) (
    // system side clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // link clock, its falling edge stands for the complement clock
    input wire logic link_clk_in,
    // command and address
    input wire logic rd_sel_n_in,
    input wire logic wr_sel_n_in,
    input wire logic [ADDR_W-1:0] shared_address_bus_in,
    // write data and byte enables
    input wire logic [DATA_W-1:0] data_in,
    input wire logic [DATA_W/`B4Q_LANE_W-1:0] byte_write_n_in,
    // output clock pair, used only as a mode strap
    input wire logic out_clk_in,
    input wire logic out_clk_n_in,
    // read data
    output logic [DATA_W-1:0] q_out,
    output logic q_oe_out,
    // echo clocks and impedance update
    output logic echo_clock_out,
    output logic echo_clock_n_out,
    output logic impedance_update_out,
    // status in the system clock domain
    output logic deselected_out,
    output logic impedance_ready_out,
    output logic single_clock_mode_out
);
    localparam int CNT_W = $clog2(IMP_CYCLES + 1);
    localparam logic [CNT_W-1:0] IMP_LAST = CNT_W'(IMP_CYCLES);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // only the two low bits step, so a burst wraps inside its group of four
    function automatic logic [ADDR_W-1:0] burst_at(input logic [ADDR_W-1:0] base,
                                                   input logic [1:0] off);
        logic [1:0] low;
        low = base[1:0] + off;
        return {base[ADDR_W-1:2], low};
    endfunction : burst_at

    // ----------------------------------------------------------------
    // reset and strap into the link domain
    // ----------------------------------------------------------------
    logic rst_meta;
    logic rst_link;
    logic [1:0] oclk_meta;
    logic [1:0] oclk_sync;
    b4q_pkg::b4q_mode_e mode;
    logic mode_locked;

    // two stages for the system reset level
    always_ff @(posedge link_clk_in) begin
        rst_meta <= rst_in;
        rst_link <= rst_meta;
    end

    // two stages for the output clock strap pins
    always_ff @(posedge link_clk_in) begin
        oclk_meta <= {out_clk_in, out_clk_n_in};
        oclk_sync <= oclk_meta;
    end

    // mode taken on the first edge after reset, frozen afterwards
    always_ff @(posedge link_clk_in) begin
        if (rst_link) begin
            mode <= b4q_pkg::B4Q_DUAL_CLOCK;
            mode_locked <= `B4Q_FLAG_RST;
        end else if (!mode_locked) begin
            mode <= (&oclk_sync) ? b4q_pkg::B4Q_SINGLE_CLOCK
                                 : b4q_pkg::B4Q_DUAL_CLOCK;
            mode_locked <= 1'h1;
        end
    end

    // ----------------------------------------------------------------
    // read burst machine
    // ----------------------------------------------------------------
    logic rd_take;
    logic r1_v;
    logic r2_v;
    logic r3_v;
    logic [ADDR_W-1:0] r1_addr;
    logic [ADDR_W-1:0] r2_addr;
    logic [ADDR_W-1:0] r3_addr;

    // a request right after an accepted one is dropped
    assign rd_take = !rd_sel_n_in && !r1_v;

    // three stage pipeline: accepted, first half, second half
    always_ff @(posedge link_clk_in) begin
        if (rst_link) begin
            r1_v <= `B4Q_FLAG_RST;
            r2_v <= `B4Q_FLAG_RST;
            r3_v <= `B4Q_FLAG_RST;
        end else begin
            r1_v <= rd_take;
            r2_v <= r1_v;
            r3_v <= r2_v;
        end
    end

    // read address register follows its burst down the pipe
    always_ff @(posedge link_clk_in) begin
        if (rst_link) begin
            r1_addr <= '0;
            r2_addr <= '0;
            r3_addr <= '0;
        end else begin
            if (rd_take) begin
                r1_addr <= shared_address_bus_in;
            end
            r2_addr <= r1_addr;
            r3_addr <= r2_addr;
        end
    end

    // ----------------------------------------------------------------
    // write burst machine
    // ----------------------------------------------------------------
    logic wr_take;
    logic w1_v;
    logic w2_v;
    logic w3_v;
    logic [ADDR_W-1:0] w1_addr;
    logic [ADDR_W-1:0] w2_addr;
    logic [ADDR_W-1:0] w3_addr;
    logic [DATA_W-1:0] wbeat_data;
    logic [DATA_W/`B4Q_LANE_W-1:0] wbeat_bw_n;

    assign wr_take = !wr_sel_n_in && !w1_v;

    // independent of the read pipe, same clock edge
    always_ff @(posedge link_clk_in) begin
        if (rst_link) begin
            w1_v <= `B4Q_FLAG_RST;
            w2_v <= `B4Q_FLAG_RST;
            w3_v <= `B4Q_FLAG_RST;
        end else begin
            w1_v <= wr_take;
            w2_v <= w1_v;
            w3_v <= w2_v;
        end
    end

    // write address register
    always_ff @(posedge link_clk_in) begin
        if (rst_link) begin
            w1_addr <= '0;
            w2_addr <= '0;
            w3_addr <= '0;
        end else begin
            if (wr_take) begin
                w1_addr <= shared_address_bus_in;
            end
            w2_addr <= w1_addr;
            w3_addr <= w2_addr;
        end
    end

    // rising-edge beats (words 0 and 2) held until the falling edge
    always_ff @(posedge link_clk_in) begin
        if (rst_link) begin
            wbeat_data <= '0;
            wbeat_bw_n <= '1;
        end else if (w1_v || w2_v) begin
            wbeat_data <= data_in;
            wbeat_bw_n <= byte_write_n_in;
        end
    end

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic st_wr_en;
    logic [ADDR_W-1:0] st_wa_addr;
    logic [ADDR_W-1:0] st_wb_addr;
    logic [ADDR_W-1:0] st_rn_addr;
    logic [ADDR_W-1:0] st_rp_addr;
    logic [DATA_W-1:0] st_rn_data;
    logic [DATA_W-1:0] st_rp_data;

    // falling edge writes words 0+1, a cycle later words 2+3
    assign st_wr_en = w2_v || w3_v;
    assign st_wa_addr = w3_v ? burst_at(w3_addr, `B4Q_OFF_2)
                             : burst_at(w2_addr, `B4Q_OFF_0);
    assign st_wb_addr = w3_v ? burst_at(w3_addr, `B4Q_OFF_3)
                             : burst_at(w2_addr, `B4Q_OFF_1);

    // read addresses for the falling and the rising launch
    assign st_rn_addr = r3_v ? burst_at(r3_addr, `B4Q_OFF_2)
                             : burst_at(r2_addr, `B4Q_OFF_0);
    assign st_rp_addr = r3_v ? burst_at(r3_addr, `B4Q_OFF_3)
                             : burst_at(r2_addr, `B4Q_OFF_1);

    b4q_store #(
        .DATA_W(DATA_W),
        .ADDR_W(ADDR_W)
    ) u_store (
        .clk_in(link_clk_in),
        .wr_en_in(st_wr_en),
        .wa_addr_in(st_wa_addr),
        .wa_data_in(wbeat_data),
        .wa_byte_n_in(wbeat_bw_n),
        .wb_addr_in(st_wb_addr),
        .wb_data_in(data_in),
        .wb_byte_n_in(byte_write_n_in),
        .ra_addr_in(st_rn_addr),
        .ra_data_out(st_rn_data),
        .rb_addr_in(st_rp_addr),
        .rb_data_out(st_rp_data)
    );

    // ----------------------------------------------------------------
    // double data rate read output
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] q_pos;
    logic [DATA_W-1:0] q_neg;
    logic oe_pos;
    logic oe_neg;

    // rising-edge words 1 and 3
    always_ff @(posedge link_clk_in) begin
        if (rst_link) begin
            q_pos <= '0;
            oe_pos <= `B4Q_FLAG_RST;
        end else begin
            oe_pos <= r2_v || r3_v;
            if (r2_v || r3_v) begin
                q_pos <= st_rp_data;
            end
        end
    end

    // falling-edge words 0 and 2; reset seen half a cycle late is harmless
    always_ff @(negedge link_clk_in) begin
        if (rst_link) begin
            q_neg <= '0;
            oe_neg <= `B4Q_FLAG_RST;
        end else begin
            oe_neg <= r2_v || r3_v;
            if (r2_v || r3_v) begin
                q_neg <= st_rn_data;
            end
        end
    end

    // clock-level select: each half cycle shows the word launched at its edge
    assign q_out = link_clk_in ? q_pos : q_neg;
    assign q_oe_out = link_clk_in ? oe_pos : oe_neg;

    // echo pair follows the launch clock, so it tracks the data exactly
    assign echo_clock_out = link_clk_in;
    assign echo_clock_n_out = ~link_clk_in;

    // ----------------------------------------------------------------
    // impedance update and non-read count
    // ----------------------------------------------------------------
    logic rd_quiet;
    logic imp_update;
    logic [CNT_W-1:0] imp_count;

    // no read anywhere in flight: outputs stay released next cycle
    assign rd_quiet = !rd_take && !r1_v && !r2_v && !r3_v;

    // update strobe only in cycles that drive no output
    always_ff @(posedge link_clk_in) begin
        if (rst_link) begin
            imp_update <= `B4Q_FLAG_RST;
        end else begin
            imp_update <= rd_quiet;
        end
    end
    assign impedance_update_out = imp_update;

    // saturating count of non-read cycles since reset
    always_ff @(posedge link_clk_in) begin
        if (rst_link) begin
            imp_count <= '0;
        end else if (!rd_take && imp_count != IMP_LAST) begin
            imp_count <= imp_count + CNT_W'(1);
        end
    end

    // ----------------------------------------------------------------
    // status levels into the system domain
    // ----------------------------------------------------------------
    logic link_idle;
    logic [2:0] stat_link;
    logic [2:0] stat_meta;
    logic [2:0] stat_sync;

    // stopped link clock simply freezes these levels
    assign link_idle = !(r1_v || r2_v || r3_v || w1_v || w2_v || w3_v);

    // registered in the link domain so the crossing sees clean levels
    always_ff @(posedge link_clk_in) begin
        if (rst_link) begin
            stat_link <= 3'h1;
        end else begin
            stat_link <= {mode == b4q_pkg::B4Q_SINGLE_CLOCK,
                          imp_count == IMP_LAST, link_idle};
        end
    end

    // two-stage synchroniser, independent levels only
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            stat_meta <= 3'h1;
            stat_sync <= 3'h1;
        end else begin
            stat_meta <= stat_link;
            stat_sync <= stat_meta;
        end
    end
    assign deselected_out = stat_sync[0];
    assign impedance_ready_out = stat_sync[1];
    assign single_clock_mode_out = stat_sync[2];

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_WR_CAPTURE: assert property (@(posedge link_clk_in) disable iff (rst_link)
        wr_take |=> w1_v && w1_addr == $past(shared_address_bus_in))
        else $error("write command not captured");

    AST_WR_NO_REPEAT: assert property (@(posedge link_clk_in) disable iff (rst_link)
        w1_v |=> !w1_v && $stable(w1_addr))
        else $error("write accepted on consecutive edges");

    AST_RD_CAPTURE: assert property (@(posedge link_clk_in) disable iff (rst_link)
        rd_take |=> r1_v && r1_addr == $past(shared_address_bus_in))
        else $error("read command not captured");

    // a read closely behind another keeps the pins busy, so time it from idle pins only
    AST_RD_OUT_WINDOW: assert property (@(posedge link_clk_in) disable iff (rst_link)
        r1_v && !oe_pos && !oe_neg |=> !oe_pos ##1 oe_pos [*2])
        else $error("read data window misplaced");

    AST_WR_BURST_RUNS: assert property (@(posedge link_clk_in) disable iff (rst_link)
        w1_v |=> st_wr_en && !w3_v ##1 st_wr_en && w3_v)
        else $error("write burst not completed");

    AST_WR_WORD_ADDR: assert property (@(posedge link_clk_in) disable iff (rst_link)
        w1_v |=> st_wb_addr[1:0] == $past(w1_addr[1:0]) + 2'h1
                 ##1 st_wa_addr[1:0] == $past(w1_addr[1:0], 2) + 2'h2)
        else $error("burst address not linear");

    AST_IMP_IDLE_ONLY: assert property (@(posedge link_clk_in) disable iff (rst_link)
        imp_update |-> !oe_pos ##1 !oe_neg)
        else $error("impedance update while driving");

    AST_NOP_RELEASED: assert property (@(posedge link_clk_in) disable iff (rst_link)
        (rd_sel_n_in && !r1_v && !r2_v && !r3_v) [*2] |=> !oe_pos && !oe_neg)
        else $error("outputs driven without a read");

    AST_MODE_FROZEN: assert property (@(posedge link_clk_in) disable iff (rst_link)
        mode_locked |=> mode_locked && $stable(mode))
        else $error("clock mode changed after reset");

    AST_DESELECT_LATE: assert property (@(posedge link_clk_in) disable iff (rst_link)
        (w1_v || r1_v) |=> !stat_link[0] ##1 !stat_link[0])
        else $error("deselected before burst end");

    COV_READ: cover property (@(posedge link_clk_in) disable iff (rst_link)
        rd_take ##3 oe_pos);
    COV_WRITE: cover property (@(posedge link_clk_in) disable iff (rst_link)
        wr_take ##2 w3_v);
    COV_BOTH: cover property (@(posedge link_clk_in) disable iff (rst_link)
        rd_take && wr_take);
    COV_READ_STREAM: cover property (@(posedge link_clk_in) disable iff (rst_link)
        rd_take ##2 rd_take);

endmodule : b4q_port

// File: core/b4q_store.sv
`timescale 1ns/10ps
`include "b4q_regs.svh"

// ----------------------------------------------------------------
// byte-lane storage array, two write ports, two read ports
// ----------------------------------------------------------------
module b4q_store #(
    parameter int DATA_W = `B4Q_DATA_W_DEF,
    parameter int ADDR_W = `B4Q_ADDR_W_DEF
) (
    // link clock, writes land on its falling edge
    input wire logic clk_in,
    // write port a (registered beat) and b (live beat)
    input wire logic wr_en_in,
    input wire logic [ADDR_W-1:0] wa_addr_in,
    input wire logic [DATA_W-1:0] wa_data_in,
    input wire logic [DATA_W/`B4Q_LANE_W-1:0] wa_byte_n_in,
    input wire logic [ADDR_W-1:0] wb_addr_in,
    input wire logic [DATA_W-1:0] wb_data_in,
    input wire logic [DATA_W/`B4Q_LANE_W-1:0] wb_byte_n_in,
    // read ports
    input wire logic [ADDR_W-1:0] ra_addr_in,
    output logic [DATA_W-1:0] ra_data_out,
    input wire logic [ADDR_W-1:0] rb_addr_in,
    output logic [DATA_W-1:0] rb_data_out
);
    localparam int LANES = DATA_W / `B4Q_LANE_W;

    // one array per lane so each byte enable owns its own storage
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        logic [`B4Q_LANE_W-1:0] lane_mem [2**ADDR_W];

        // low enable stores the lane, high leaves it untouched
        always_ff @(negedge clk_in) begin
            if (wr_en_in && !wa_byte_n_in[g]) begin
                lane_mem[wa_addr_in] <= wa_data_in[g*`B4Q_LANE_W +: `B4Q_LANE_W];
            end
            if (wr_en_in && !wb_byte_n_in[g]) begin
                lane_mem[wb_addr_in] <= wb_data_in[g*`B4Q_LANE_W +: `B4Q_LANE_W];
            end
        end

        // asynchronous read; the caller registers the result
        assign ra_data_out[g*`B4Q_LANE_W +: `B4Q_LANE_W] = lane_mem[ra_addr_in];
        assign rb_data_out[g*`B4Q_LANE_W +: `B4Q_LANE_W] = lane_mem[rb_addr_in];
    end

endmodule : b4q_store
